// ===== rtl/tnr_pkg.sv
// shared constants and types of the node register block
package tnr_pkg;

  // register offsets on the host port
  localparam logic [2:0] OFS_INT_MASK = 3'h0; // write: mask, read: node_state_flags
  localparam logic [2:0] OFS_COMMAND = 3'h1; // write: command, read: diagnostic_flags
  localparam logic [2:0] OFS_PTR_HIGH = 3'h2;
  localparam logic [2:0] OFS_PTR_LOW = 3'h3;
  localparam logic [2:0] OFS_DATA = 3'h4;
  localparam logic [2:0] OFS_BANK_SEL = 3'h5;
  localparam logic [2:0] OFS_MODE_CFG = 3'h6;
  localparam logic [2:0] OFS_BANKED = 3'h7;

  // bank codes at the banked offset
  localparam logic [2:0] BANK_PROBE_ID = 3'h0;
  localparam logic [2:0] BANK_OWN_ID = 3'h1;
  localparam logic [2:0] BANK_SPEED_SETUP = 3'h2;
  localparam logic [2:0] BANK_SUCCESSOR_ID = 3'h3;
  localparam logic [2:0] BANK_SECOND_SETUP = 3'h4;

  // status and mask bit positions
  localparam int BIT_RX_INHIBITED = 7;
  localparam int BIT_POWER_ON = 4;
  localparam int BIT_RECONFIG = 2;
  localparam int BIT_TX_AVAILABLE = 0;
  // diagnostic bit positions
  localparam int BIT_MY_RECON = 7;
  localparam int BIT_DUPLICATE = 6;
  localparam int BIT_RX_ACTIVITY = 5;
  localparam int BIT_TOKEN_SEEN = 4;
  localparam int BIT_EXCESS_REFUSAL = 3;
  localparam int BIT_PROBE_FOUND = 2;
  localparam int BIT_NEW_SUCCESSOR = 1;
  // pointer high fields
  localparam int BIT_PTR_READ = 7;
  localparam int BIT_PTR_AUTOINC = 6;
  // mode configuration fields
  localparam int BIT_CFG_SOFT_RESET = 7;
  localparam int BIT_CFG_TX_JOIN = 5;
  // bank select fields
  localparam int BIT_BANK2 = 2;

  // reset values
  localparam logic [7:0] RST_INT_MASK = 8'h00;
  localparam logic [7:0] RST_MODE_CFG = 8'h18;
  localparam logic [7:0] RST_ID = 8'h00;
  localparam logic [7:0] RST_SETUP = 8'h00;
  localparam logic [7:0] RST_DIAG = 8'h00;

  // command codes acted on here; all codes are still passed to the core
  localparam logic [7:0] CMD_CLEAR_FLAGS = 8'h0e;
  localparam logic [7:0] CMD_POR_CLEAR_FLAGS = 8'h1e;

  // maskable sources: positions shared by status and diagnostic bits
  localparam logic [7:0] INT_SOURCES = 8'h8f;

  // pulses and levels from the protocol core (same clock)
  typedef struct packed {
    logic rx_inhibited;
    logic tx_available;
    logic recon_evt;
    logic excess_refusal_evt;
    logic successor_upd;
    logic [7:0] successor_id;
    logic my_recon_evt;
    logic duplicate_evt;
    logic rx_activity_evt;
    logic token_evt;
    logic probe_found_evt;
  } tnr_core_evt_s;

  // settings handed to the protocol core
  typedef struct packed {
    logic awake;
    logic join_enable;
    logic soft_reset;
    logic [7:0] mode_cfg;
    logic [7:0] speed_setup;
    logic [7:0] second_setup;
    logic [7:0] own_node_id;
    logic [7:0] probe_node_id;
    logic probe_stb;
    logic [7:0] cmd_code;
    logic cmd_stb;
  } tnr_core_ctl_s;

  // host register port
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tnr_host_req_s;

endpackage

// ===== rtl/tnr_regs.sv
// host register file of a token-passing network node controller
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps

module tnr_regs #(
  parameter int RAM_ADDR_W = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host register port
  input wire tnr_pkg::tnr_host_req_s host_req,
  output logic [7:0] host_rdata,
  // protocol core
  input wire tnr_pkg::tnr_core_evt_s core_evt,
  output tnr_pkg::tnr_core_ctl_s core_ctl,
  // interrupt to host
  output logic irq
);
  import tnr_pkg::*;

  localparam int RAM_DEPTH = 1 << RAM_ADDR_W;

  generate
    if (RAM_ADDR_W < 9 || RAM_ADDR_W > 11) begin : g_bad_width
      $error("RAM_ADDR_W must lie between 9 and 11");
    end
    if (BANK_SECOND_SETUP != 3'h4) begin : g_bad_bank
      $error("second setup must be the only code using the third select bit");
    end
  endgenerate

  typedef struct packed {
    logic [7:0] int_mask;
    logic [7:0] ptr_high;
    logic [7:0] ptr_low;
    logic [RAM_ADDR_W-1:0] ram_addr;
    logic [7:0] data;
    logic [1:0] bank_upper;
    logic bank2;
    logic [7:0] mode_cfg;
    logic [7:0] probe_id;
    logic [7:0] own_id;
    logic [7:0] speed_setup;
    logic [7:0] second_setup;
    logic [7:0] successor_id;
    logic rx_inhibited;
    logic tx_available;
    logic power_on;
    logic reconfig;
    logic [7:0] diag;
    logic [7:0] rdata;
    logic [7:0] cmd_code;
    logic cmd_stb;
    logic probe_stb;
    logic irq;
    logic awake;
    logic join_en;
  } tnr_state_s;

  logic [7:0] ram_r [RAM_DEPTH];
  tnr_state_s st_r;
  tnr_state_s st_nxt;

  // flags and pointer helpers
  logic [2:0] bank_code;
  logic [7:0] status_val;
  logic [7:0] int_src;
  logic [RAM_ADDR_W-1:0] low_addr;
  logic [RAM_ADDR_W-1:0] inc_addr;
  logic ram_we;
  logic soft_rst;
  logic core_on;

  always_comb begin
    // third select bit sits above the two mirrored configuration bits
    bank_code = {st_r.bank2, st_r.mode_cfg[1:0]};
    status_val = 8'h00;
    status_val[BIT_RX_INHIBITED] = st_r.rx_inhibited;
    status_val[BIT_POWER_ON] = st_r.power_on;
    status_val[BIT_RECONFIG] = st_r.reconfig;
    status_val[BIT_TX_AVAILABLE] = st_r.tx_available;
    low_addr = RAM_ADDR_W'({st_r.ptr_high[2:0], host_req.wdata});
    inc_addr = st_r.ram_addr + RAM_ADDR_W'(1);
    ram_we = host_req.wr && host_req.addr == OFS_DATA;
    soft_rst = st_r.mode_cfg[BIT_CFG_SOFT_RESET];
    core_on = st_r.awake;
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd_stb = 1'b0;
    st_nxt.probe_stb = 1'b0;
    st_nxt.rdata = 8'h00;
    int_src = 8'h00;

    // host writes
    if (host_req.wr) begin
      case (host_req.addr)
        OFS_INT_MASK: begin
          st_nxt.int_mask = host_req.wdata;
        end
        OFS_COMMAND: begin
          st_nxt.cmd_code = host_req.wdata;
          st_nxt.cmd_stb = 1'b1;
          if (host_req.wdata == CMD_CLEAR_FLAGS || host_req.wdata == CMD_POR_CLEAR_FLAGS) begin
            st_nxt.power_on = 1'b0;
            st_nxt.reconfig = 1'b0;
          end
          if (host_req.wdata == CMD_POR_CLEAR_FLAGS) begin
            st_nxt.diag[BIT_EXCESS_REFUSAL] = 1'b0;
          end
        end
        OFS_PTR_HIGH: begin
          st_nxt.ptr_high = host_req.wdata;
        end
        OFS_PTR_LOW: begin
          st_nxt.ptr_low = host_req.wdata;
          // the address only moves on the low byte, so a half-written pointer is never used
          st_nxt.ram_addr = low_addr;
          if (st_r.ptr_high[BIT_PTR_READ]) begin
            st_nxt.data = ram_r[low_addr];
          end
        end
        OFS_DATA: begin
          st_nxt.data = host_req.wdata;
          if (st_r.ptr_high[BIT_PTR_AUTOINC]) begin
            st_nxt.ram_addr = inc_addr;
          end
        end
        OFS_BANK_SEL: begin
          st_nxt.bank_upper = host_req.wdata[7:6];
          st_nxt.bank2 = host_req.wdata[BIT_BANK2];
          st_nxt.mode_cfg[1:0] = host_req.wdata[1:0];
        end
        OFS_MODE_CFG: begin
          st_nxt.mode_cfg = host_req.wdata;
          st_nxt.bank2 = 1'b0;
        end
        OFS_BANKED: begin
          case (bank_code)
            BANK_PROBE_ID: begin
              st_nxt.probe_id = host_req.wdata;
              st_nxt.probe_stb = 1'b1;
            end
            BANK_OWN_ID: begin
              st_nxt.own_id = host_req.wdata;
              if (host_req.wdata == 8'h00) begin
                st_nxt.power_on = 1'b1;
              end
            end
            BANK_SPEED_SETUP: begin
              st_nxt.speed_setup = host_req.wdata;
            end
            BANK_SECOND_SETUP: begin
              st_nxt.second_setup = host_req.wdata;
            end
            default: begin
            end
          endcase
        end
        default: begin
        end
      endcase
    end

    // host reads and their side effects
    if (host_req.rd) begin
      case (host_req.addr)
        OFS_INT_MASK: begin
          st_nxt.rdata = status_val;
        end
        OFS_COMMAND: begin
          st_nxt.rdata = {st_r.diag[7:1], 1'b0};
          // new successor and excess refusal survive a read; they have their own clears
          st_nxt.diag[BIT_MY_RECON] = 1'b0;
          st_nxt.diag[BIT_DUPLICATE] = 1'b0;
          st_nxt.diag[BIT_RX_ACTIVITY] = 1'b0;
          st_nxt.diag[BIT_TOKEN_SEEN] = 1'b0;
          st_nxt.diag[BIT_PROBE_FOUND] = 1'b0;
          st_nxt.diag[0] = 1'b0;
        end
        OFS_PTR_HIGH: begin
          st_nxt.rdata = {st_r.ptr_high[7:6], 3'h0, st_r.ptr_high[2:0]};
        end
        OFS_PTR_LOW: begin
          st_nxt.rdata = st_r.ptr_low;
        end
        OFS_DATA: begin
          st_nxt.rdata = st_r.data;
          if (st_r.ptr_high[BIT_PTR_AUTOINC]) begin
            st_nxt.ram_addr = inc_addr;
            st_nxt.data = ram_r[inc_addr];
          end
        end
        OFS_BANK_SEL: begin
          st_nxt.rdata = {st_r.bank_upper, 3'h0, st_r.bank2, st_r.mode_cfg[1:0]};
        end
        OFS_MODE_CFG: begin
          st_nxt.rdata = st_r.mode_cfg;
        end
        OFS_BANKED: begin
          case (bank_code)
            BANK_PROBE_ID: st_nxt.rdata = st_r.probe_id;
            BANK_OWN_ID: st_nxt.rdata = st_r.own_id;
            BANK_SPEED_SETUP: st_nxt.rdata = st_r.speed_setup;
            BANK_SUCCESSOR_ID: begin
              st_nxt.rdata = st_r.successor_id;
              st_nxt.diag[BIT_NEW_SUCCESSOR] = 1'b0;
            end
            BANK_SECOND_SETUP: st_nxt.rdata = st_r.second_setup;
            default: st_nxt.rdata = 8'h00;
          endcase
        end
        default: begin
          st_nxt.rdata = 8'h00;
        end
      endcase
    end

    // core events: an event in the clearing cycle wins
    st_nxt.rx_inhibited = core_evt.rx_inhibited;
    st_nxt.tx_available = core_evt.tx_available;
    // events from a sleeping core are dropped
    if (core_on) begin
      if (core_evt.recon_evt) begin
        st_nxt.reconfig = 1'b1;
      end
      if (core_evt.excess_refusal_evt) begin
        st_nxt.diag[BIT_EXCESS_REFUSAL] = 1'b1;
      end
      if (core_evt.successor_upd) begin
        st_nxt.successor_id = core_evt.successor_id;
        st_nxt.diag[BIT_NEW_SUCCESSOR] = 1'b1;
      end
      if (core_evt.my_recon_evt) begin
        st_nxt.diag[BIT_MY_RECON] = 1'b1;
      end
      if (core_evt.duplicate_evt) begin
        st_nxt.diag[BIT_DUPLICATE] = 1'b1;
      end
      if (core_evt.rx_activity_evt) begin
        st_nxt.diag[BIT_RX_ACTIVITY] = 1'b1;
      end
      if (core_evt.token_evt) begin
        st_nxt.diag[BIT_TOKEN_SEEN] = 1'b1;
      end
      if (core_evt.probe_found_evt) begin
        st_nxt.diag[BIT_PROBE_FOUND] = 1'b1;
      end
    end

    // software reset held by the configuration reset bit
    if (soft_rst) begin
      st_nxt.successor_id = RST_ID;
      st_nxt.rx_inhibited = 1'b1;
      st_nxt.tx_available = 1'b1;
      st_nxt.power_on = 1'b1;
      st_nxt.reconfig = 1'b0;
      st_nxt.diag = RST_DIAG;
    end

    // core wake and join
    st_nxt.awake = st_nxt.own_id != 8'h00 && !st_nxt.mode_cfg[BIT_CFG_SOFT_RESET];
    st_nxt.join_en = st_nxt.awake && st_nxt.mode_cfg[BIT_CFG_TX_JOIN];

    // interrupt from next flag values
    int_src[BIT_RX_INHIBITED] = st_nxt.rx_inhibited;
    int_src[BIT_EXCESS_REFUSAL] = st_nxt.diag[BIT_EXCESS_REFUSAL];
    int_src[BIT_RECONFIG] = st_nxt.reconfig;
    int_src[BIT_NEW_SUCCESSOR] = st_nxt.diag[BIT_NEW_SUCCESSOR];
    int_src[BIT_TX_AVAILABLE] = st_nxt.tx_available;
    st_nxt.irq = |(int_src & st_nxt.int_mask);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // pointers and data window clear to zero; only the ram is left as it was
      st_r <= '0;
      st_r.int_mask <= RST_INT_MASK;
      st_r.mode_cfg <= RST_MODE_CFG;
      st_r.probe_id <= RST_ID;
      st_r.own_id <= RST_ID;
      st_r.speed_setup <= RST_SETUP;
      st_r.second_setup <= RST_SETUP;
      st_r.successor_id <= RST_ID;
      st_r.rx_inhibited <= 1'b1;
      st_r.tx_available <= 1'b1;
      st_r.power_on <= 1'b1;
      st_r.diag <= RST_DIAG;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ram array: host writes through the data window
  always_ff @(posedge clk) begin
    if (ram_we) begin
      ram_r[st_r.ram_addr] <= host_req.wdata;
    end
  end

  always_comb begin
    // every output is a register copy; nothing combinational reaches a pin
    host_rdata = st_r.rdata;
    irq = st_r.irq;
    core_ctl.awake = st_r.awake;
    core_ctl.join_enable = st_r.join_en;
    core_ctl.soft_reset = st_r.mode_cfg[BIT_CFG_SOFT_RESET];
    core_ctl.mode_cfg = st_r.mode_cfg;
    core_ctl.speed_setup = st_r.speed_setup;
    core_ctl.second_setup = st_r.second_setup;
    core_ctl.own_node_id = st_r.own_id;
    core_ctl.probe_node_id = st_r.probe_id;
    core_ctl.probe_stb = st_r.probe_stb;
    core_ctl.cmd_code = st_r.cmd_code;
    core_ctl.cmd_stb = st_r.cmd_stb;
  end

endmodule

// ===== tb/tnr_regs_properties.sv
// bound checker for the node register block
`timescale 1ns/1ps
module tnr_regs_properties #(
  parameter int RAM_ADDR_W = 11
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // host port
  input wire tnr_pkg::tnr_host_req_s host_req,
  input wire logic [7:0] host_rdata,
  // core side
  input wire tnr_pkg::tnr_core_evt_s core_evt,
  input wire tnr_pkg::tnr_core_ctl_s core_ctl,
  input wire logic irq
);
  import tnr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  rdata_idle_a: assert property (!$past(host_req.rd) |-> host_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  irq_reset_a: assert property ($rose(rst_n) && !host_req.wr |=> !irq)
    else $error("interrupt raised right after reset");
  core_sleep_a: assert property (core_ctl.own_node_id == 8'h00 &&
    $past(core_ctl.own_node_id) == 8'h00 |-> !core_ctl.awake)
    else $error("core awake with zero node id");
  join_gate_a: assert property (!core_ctl.mode_cfg[5] && !$past(core_ctl.mode_cfg[5])
    |-> !core_ctl.join_enable)
    else $error("join enabled without transmit enable");
  cmd_pass_a: assert property (host_req.wr && host_req.addr == OFS_COMMAND
    |=> core_ctl.cmd_stb && core_ctl.cmd_code == $past(host_req.wdata))
    else $error("command not passed on");
  irq_masked_a: assert property ((host_req.wr && host_req.addr == OFS_INT_MASK &&
    host_req.wdata == 8'h00) ##1 !(host_req.wr && host_req.addr == OFS_INT_MASK) |=> !irq)
    else $error("interrupt with all masks clear");
  probe_strobe_a: assert property (core_ctl.probe_stb |-> $past(host_req.wr) &&
    $past(host_req.addr) == OFS_BANKED && core_ctl.probe_node_id == $past(host_req.wdata))
    else $error("probe strobe without probe write");
  soft_reset_a: assert property (core_ctl.mode_cfg[7] && $past(core_ctl.mode_cfg[7]) &&
    $past(core_ctl.mode_cfg[7], 2) |-> core_ctl.soft_reset && !core_ctl.awake)
    else $error("soft reset not applied");
  cfg_read_a: assert property (host_req.rd && host_req.addr == OFS_MODE_CFG
    |=> host_rdata == $past(core_ctl.mode_cfg))
    else $error("configuration read mismatch");
  bank_mirror_a: assert property (host_req.wr && host_req.addr == OFS_BANK_SEL
    |=> core_ctl.mode_cfg[1:0] == $past(host_req.wdata[1:0]))
    else $error("bank bits not mirrored");
endmodule

bind tnr_regs tnr_regs_properties #(.RAM_ADDR_W(RAM_ADDR_W)) tnr_regs_properties_i (
  .clk(clk), .rst_n(rst_n), .host_req(host_req), .host_rdata(host_rdata),
  .core_evt(core_evt), .core_ctl(core_ctl), .irq(irq));

// ===== tb/tnr_core_model.sv
// behavioural protocol core driving the event port of the register block
`timescale 1ns/1ps
module tnr_core_model #(
  parameter logic [7:0] PRESENT_ID = 8'h2a,
  parameter int PROBE_DLY = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // settings from the register block
  input wire tnr_pkg::tnr_core_ctl_s core_ctl,
  // event requests from the bench
  input wire tnr_pkg::tnr_core_evt_s kick,
  // events towards the register block
  output tnr_pkg::tnr_core_evt_s core_evt
);
  import tnr_pkg::*;
  int probe_cnt;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      // receiver levels run through reset so status shows them from the first cycle
      core_evt <= '0;
      core_evt.rx_inhibited <= kick.rx_inhibited;
      core_evt.tx_available <= kick.tx_available;
      probe_cnt <= 0;
    end else begin
      // a sleeping core raises no events, only its receiver levels
      core_evt <= core_ctl.awake ? kick : '0;
      core_evt.rx_inhibited <= kick.rx_inhibited;
      core_evt.tx_available <= kick.tx_available;
      // a present probed node answers some cycles later
      if (core_ctl.probe_stb && core_ctl.probe_node_id == PRESENT_ID) begin
        probe_cnt <= PROBE_DLY;
      end else if (probe_cnt > 0) begin
        probe_cnt <= probe_cnt - 1;
      end
      if (probe_cnt == 1 && core_ctl.awake) begin
        core_evt.probe_found_evt <= 1'b1;
      end
    end
  end
endmodule

// ===== tb/testbench.sv
// self-checking bench of the node register block
`timescale 1ns/1ps
module testbench;
  import tnr_pkg::*;
  logic clk, rst_n, irq;
  tnr_host_req_s host_req;
  logic [7:0] host_rdata, v, own;
  tnr_core_evt_s core_evt, kick;
  tnr_core_ctl_s core_ctl;
  int errors, check_count;
  logic [7:0] mem [4];
  logic [10:0] base;

  tnr_regs #(.RAM_ADDR_W(11)) tnr_regs_i (.clk(clk), .rst_n(rst_n), .host_req(host_req),
    .host_rdata(host_rdata), .core_evt(core_evt), .core_ctl(core_ctl), .irq(irq));
  tnr_core_model tnr_core_model_i (.clk(clk), .rst_n(rst_n), .core_ctl(core_ctl),
    .kick(kick), .core_evt(core_evt));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(string name, logic [7:0] exp, logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      errors++;
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk);
    host_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    host_req.wr <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a, logic [7:0] m, logic [7:0] exp, string name);
    @(posedge clk);
    host_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    host_req.rd <= 1'b0;
    #1 check(name, exp, host_rdata & m);
  endtask

  task automatic bank(logic [2:0] b);
    wr(OFS_BANK_SEL, {5'h00, b});
  endtask

  task automatic pulse(tnr_core_evt_s e);
    @(posedge clk);
    kick <= kick | e;
    @(posedge clk);
    kick <= kick & ~e;
  endtask

  task automatic flag(logic exp, string name);
    repeat (3) @(posedge clk);
    #1 check(name, {7'h00, exp}, {7'h00, irq});
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    end_sim();
  end

  initial begin
    host_req = '0;
    kick = '0;
    kick.rx_inhibited = 1'b1;
    kick.tx_available = 1'b1;
    rst_n = 1'b0;
    errors = 0;
    check_count = 0;
    own = 8'h01;
    void'($urandom(76));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(OFS_INT_MASK, 8'h9f, 8'h91, "status");
    rd(OFS_COMMAND, 8'hfe, 8'h00, "diag");
    rd(OFS_MODE_CFG, 8'hff, 8'h18, "config");
    check("irq", 8'h00, {7'h00, irq});
    for (int i = 0; i < 5; i++) begin
      bank(3'(i));
      rd(OFS_BANKED, 8'hff, 8'h00, "bank reset");
      v = 8'($urandom);
      if (i == 1) v |= 8'h01;
      if (i == 1) own = v;
      if (i == 2) v &= 8'hdf;
      if (i == 4) v &= 8'h8f;
      wr(OFS_BANKED, v);
      rd(OFS_BANKED, 8'hff, (i == 3) ? 8'h00 : v, "bank data");
      rd(OFS_MODE_CFG, 8'h03, 8'(i & 3), "bank mirror");
    end
    bank(3'h5);
    rd(OFS_BANKED, 8'hff, 8'h00, "bank unused");
    wr(OFS_MODE_CFG, 8'h19);
    rd(OFS_BANK_SEL, 8'h07, 8'h01, "bank select");
    rd(OFS_BANKED, 8'hff, own, "own id");
    $display("test banks done");
    check("awake", 8'h01, {7'h00, core_ctl.awake});
    check("join", 8'h00, {7'h00, core_ctl.join_enable});
    wr(OFS_MODE_CFG, 8'h39);
    flag(1'b0, "irq");
    check("join", 8'h01, {7'h00, core_ctl.join_enable});
    wr(OFS_BANKED, 8'h00);
    flag(1'b0, "irq");
    check("awake", 8'h00, {7'h00, core_ctl.awake});
    rd(OFS_INT_MASK, 8'h10, 8'h10, "power flag");
    wr(OFS_BANKED, own);
    wr(OFS_COMMAND, CMD_CLEAR_FLAGS);
    rd(OFS_INT_MASK, 8'h14, 8'h00, "flags cleared");
    $display("test node id done");
    for (int j = 0; j < 2; j++) begin
      v = j ? 8'h01 : 8'h80;
      wr(OFS_INT_MASK, v);
      flag(1'b1, "level irq");
      wr(OFS_INT_MASK, 8'h00);
      flag(1'b0, "masked irq");
      wr(OFS_INT_MASK, v);
      flag(1'b1, "unmasked irq");
      @(posedge clk);
      if (j) kick.tx_available <= 1'b0;
      else kick.rx_inhibited <= 1'b0;
      flag(1'b0, "level gone");
    end
    wr(OFS_INT_MASK, 8'h04);
    pulse('{recon_evt: 1'b1, default: '0});
    flag(1'b1, "recon irq");
    wr(OFS_COMMAND, CMD_CLEAR_FLAGS);
    flag(1'b0, "recon cleared");
    wr(OFS_INT_MASK, 8'h08);
    pulse('{excess_refusal_evt: 1'b1, default: '0});
    wr(OFS_COMMAND, CMD_CLEAR_FLAGS);
    flag(1'b1, "refusal kept");
    wr(OFS_COMMAND, CMD_POR_CLEAR_FLAGS);
    flag(1'b0, "refusal cleared");
    wr(OFS_INT_MASK, 8'h02);
    v = 8'($urandom);
    pulse('{successor_upd: 1'b1, successor_id: v, default: '0});
    flag(1'b1, "successor irq");
    bank(3'h3);
    rd(OFS_BANKED, 8'hff, v, "successor");
    flag(1'b0, "successor cleared");
    wr(OFS_INT_MASK, 8'h8f);
    pulse('{my_recon_evt: 1'b1, duplicate_evt: 1'b1, rx_activity_evt: 1'b1,
      token_evt: 1'b1, default: '0});
    bank(3'h0);
    wr(OFS_BANKED, 8'h2a);
    repeat (6) @(posedge clk);
    flag(1'b0, "diag no irq");
    rd(OFS_COMMAND, 8'hfe, 8'hf4, "diag set");
    rd(OFS_COMMAND, 8'hfe, 8'h00, "diag read clear");
    $display("test interrupts done");
    base = 11'($urandom_range(2043, 0));
    wr(OFS_PTR_HIGH, {5'h08, base[10:8]});
    wr(OFS_PTR_LOW, base[7:0]);
    for (int k = 0; k < 4; k++) begin
      mem[k] = 8'($urandom);
      wr(OFS_DATA, mem[k]);
    end
    wr(OFS_PTR_HIGH, {5'h18, base[10:8]});
    wr(OFS_PTR_LOW, base[7:0]);
    rd(OFS_PTR_HIGH, 8'hc7, {5'h18, base[10:8]}, "pointer high");
    rd(OFS_PTR_LOW, 8'hff, base[7:0], "pointer low");
    for (int k = 0; k < 4; k++) rd(OFS_DATA, 8'hff, mem[k], "ram data");
    $display("test data window done");
    pulse('{successor_upd: 1'b1, successor_id: 8'h55, default: '0});
    wr(OFS_MODE_CFG, 8'hb9);
    rd(OFS_INT_MASK, 8'h9f, 8'h91, "soft status");
    rd(OFS_COMMAND, 8'hfe, 8'h00, "soft diag");
    rd(OFS_MODE_CFG, 8'hff, 8'hb9, "soft config");
    bank(3'h3);
    rd(OFS_BANKED, 8'hff, 8'h00, "soft successor");
    wr(OFS_MODE_CFG, 8'h39);
    rd(OFS_INT_MASK, 8'h9f, 8'h10, "after soft");
    $display("test soft reset done");
    end_sim();
  end
endmodule
